/* File: rtl/control_port_dev.sv */
module control_port_dev (
    input  wire logic       core_clk_i,
    input  wire logic       rstn_i,
    ctrl_port_if.device     port,
    output logic            wr_strobe_o,
    output logic [7:0]      wr_addr_o,
    output logic [7:0]      wr_data_o,
    output logic            spi_mode_o
);
    localparam int NUM_REGS = ctrl_port_pkg::NUM_REGS;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_RX, ST_ACK, ST_TX, ST_MACK
    } state_t;

    state_t     state_reg, state_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next;
    logic [7:0] tx_reg, tx_next;
    logic [7:0] ptr_reg, ptr_next;
    logic       done_reg, done_next;
    logic       rw_reg, rw_next;
    logic       first_reg, first_next;
    logic [1:0] sel_reg, sel_next;
    logic [1:0] idx_reg, idx_next;
    logic       spi_reg, spi_next;
    logic       oe_reg, oe_next;
    logic       out_reg, out_next;
    logic       we_reg, we_next;
    logic [7:0] wa_reg, wa_next;
    logic [7:0] wd_reg, wd_next;
    logic       scl_prev_reg, sda_prev_reg, cs_prev_reg;
    logic [7:0] mem [NUM_REGS];
    logic [7:0] byte_out;
    logic [7:0] sh_in;
    logic       scl_rise, scl_fall, start_cond, stop_cond, cs_fall;
    logic       addr_hit;

    // edges are seen in the cycle the pin changes; both pins are sampled alike so the
    // start/stop ordering against the clock is kept
    assign scl_rise   = port.scl & ~scl_prev_reg;
    assign scl_fall   = ~port.scl & scl_prev_reg;
    assign start_cond = port.scl & scl_prev_reg & sda_prev_reg
                        & ~port.sda_line;
    assign stop_cond  = port.scl & scl_prev_reg & ~sda_prev_reg
                        & port.sda_line;
    assign cs_fall    = cs_prev_reg & ~port.latch_pin;
    // cin_pin and latch_pin serve as the address selects in I2C mode
    assign addr_hit   = sh_reg[7:1] == {port.cin_pin, port.latch_pin,
                                        ctrl_port_pkg::DEV_ADDR_LOW5};
    // out-of-map pointers read back as zero
    assign byte_out   = (ptr_reg <= ctrl_port_pkg::REG_LAST)
                        ? mem[ptr_reg[4:0]] : 8'h00;
    // received byte including the bit on the current rising clock
    assign sh_in      = spi_reg ? {sh_reg[6:0], port.cin_pin}
                                : {sh_reg[6:0], port.sda_line};

    // next-state for both protocol engines; no master clock is involved
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        sh_next    = sh_reg;
        tx_next    = tx_reg;
        ptr_next   = ptr_reg;
        done_next  = done_reg;
        rw_next    = rw_reg;
        first_next = first_reg;
        sel_next   = sel_reg;
        idx_next   = idx_reg;
        spi_next   = spi_reg;
        oe_next    = oe_reg;
        out_next   = out_reg;
        we_next    = 1'b0;
        wa_next    = ptr_reg;
        wd_next    = sh_in;
        if (!spi_reg) begin
            out_next = 1'b0;                 // open drain: only pulls low
            // select transfers count but get no answer and touch nothing;
            // the switch waits for the third select to end, so the clocks
            // of that dummy transfer never reach the spi engine
            if (cs_fall) begin
                sel_next = sel_reg + 2'h1;
            end
            if (port.latch_pin
                && sel_reg == ctrl_port_pkg::SEL_ENTER + 2'h1) begin
                spi_next = 1'b1;
            end
            if (stop_cond) begin
                state_next = ST_IDLE;
                oe_next    = 1'b0;
            end else if (start_cond) begin
                state_next = ST_ADDR;
                cnt_next   = 3'h0;
                done_next  = 1'b0;
                oe_next    = 1'b0;
            end else begin
                case (state_reg)
                    ST_ADDR, ST_RX: begin
                        if (scl_rise) begin
                            sh_next  = sh_in;
                            cnt_next = cnt_reg + 3'h1;
                            if (cnt_reg == 3'h7) begin
                                done_next = 1'b1;
                            end
                        end else if (scl_fall && done_reg) begin
                            done_next = 1'b0;
                            if (state_reg == ST_ADDR) begin
                                if (addr_hit) begin
                                    rw_next    = sh_reg[0];
                                    first_next = ~sh_reg[0];
                                    oe_next    = 1'b1;
                                    state_next = ST_ACK;
                                end else begin
                                    state_next = ST_IDLE;
                                end
                            end else begin
                                if (first_reg) begin
                                    ptr_next   = sh_reg;
                                    first_next = 1'b0;
                                end else begin
                                    we_next  = ptr_reg <=
                                               ctrl_port_pkg::REG_LAST;
                                    wd_next  = sh_reg;
                                    ptr_next = ptr_reg + 8'h01;
                                end
                                oe_next    = 1'b1;
                                state_next = ST_ACK;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            cnt_next = 3'h0;
                            if (rw_reg) begin
                                tx_next    = {byte_out[6:0], 1'b0};
                                oe_next    = ~byte_out[7];
                                ptr_next   = ptr_reg + 8'h01;
                                state_next = ST_TX;
                            end else begin
                                oe_next    = 1'b0;
                                state_next = ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            cnt_next = cnt_reg + 3'h1;
                            if (cnt_reg == 3'h7) begin
                                oe_next    = 1'b0;  // master owns the ack
                                state_next = ST_MACK;
                            end else begin
                                oe_next = ~tx_reg[7];
                                tx_next = {tx_reg[6:0], 1'b0};
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            if (port.sda_line) begin
                                state_next = ST_IDLE; // no ack: wait for stop
                            end else begin
                                done_next = 1'b1;
                            end
                        end else if (scl_fall && done_reg) begin
                            done_next  = 1'b0;
                            cnt_next   = 3'h0;
                            tx_next    = {byte_out[6:0], 1'b0};
                            oe_next    = ~byte_out[7];
                            ptr_next   = ptr_reg + 8'h01;
                            state_next = ST_TX;
                        end
                    end
                    default: begin
                        state_next = ST_IDLE;
                    end
                endcase
            end
        end else begin
            // spi: data out is push-pull and only driven while reading
            if (port.latch_pin) begin
                cnt_next = 3'h0;
                idx_next = 2'h0;
                oe_next  = 1'b0;
            end else if (scl_rise) begin
                sh_next  = sh_in;
                cnt_next = cnt_reg + 3'h1;
                if (cnt_reg == 3'h7) begin
                    if (idx_reg == 2'h0) begin
                        rw_next = sh_in[0];
                    end else if (idx_reg == 2'h1) begin
                        ptr_next = sh_in;
                    end else if (!rw_reg) begin
                        we_next  = ptr_reg <= ctrl_port_pkg::REG_LAST;
                        ptr_next = ptr_reg + 8'h01;
                    end
                    if (idx_reg != 2'h2) begin
                        idx_next = idx_reg + 2'h1;
                    end
                end
            end else if (scl_fall && rw_reg && idx_reg == 2'h2) begin
                oe_next = 1'b1;
                if (cnt_reg == 3'h0) begin
                    out_next = byte_out[7];
                    tx_next  = {byte_out[6:0], 1'b0};
                    ptr_next = ptr_reg + 8'h01;
                end else begin
                    out_next = tx_reg[7];
                    tx_next  = {tx_reg[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            state_reg    <= ST_IDLE;
            cnt_reg      <= 3'h0;
            sh_reg       <= 8'h00;
            tx_reg       <= 8'h00;
            ptr_reg      <= 8'h00;
            done_reg     <= 1'b0;
            rw_reg       <= 1'b0;
            first_reg    <= 1'b0;
            sel_reg      <= 2'h0;
            idx_reg      <= 2'h0;
            spi_reg      <= 1'b0;
            oe_reg       <= 1'b0;
            out_reg      <= 1'b0;
            we_reg       <= 1'b0;
            wa_reg       <= 8'h00;
            wd_reg       <= 8'h00;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            cs_prev_reg  <= 1'b0;   // a low start never fakes a select
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            sh_reg       <= sh_next;
            tx_reg       <= tx_next;
            ptr_reg      <= ptr_next;
            done_reg     <= done_next;
            rw_reg       <= rw_next;
            first_reg    <= first_next;
            sel_reg      <= sel_next;
            idx_reg      <= idx_next;
            spi_reg      <= spi_next;
            oe_reg       <= oe_next;
            out_reg      <= out_next;
            we_reg       <= we_next;
            wa_reg       <= wa_next;
            wd_reg       <= wd_next;
            scl_prev_reg <= port.scl;
            sda_prev_reg <= port.sda_line;
            cs_prev_reg  <= port.latch_pin;
        end
    end

    // register file; the write lands one cycle after the strobe is formed
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                mem[i] <= ctrl_port_pkg::REG_RESET;
            end
        end else if (we_reg) begin
            mem[wa_reg[4:0]] <= wd_reg;
        end
    end

    assign port.dev_sda_oe  = oe_reg;
    assign port.dev_sda_out = out_reg;
    assign wr_strobe_o      = we_reg;
    assign wr_addr_o        = wa_reg;
    assign wr_data_o        = wd_reg;
    assign spi_mode_o       = spi_reg;
endmodule : control_port_dev

/* File: common/ctrl_port_pkg.sv */
// Notes on behaviour
// - byte registers at 0x00..0x1A, both modes
// - port is slave only; master starts everything
// - register access needs no master clock
// - starts in I2C; three selects enter SPI
// - address is selects then fixed 10001, then R/W
// - selects give addresses 0x11, 0x31, 0x51, 0x71
// - first byte bit 0: one reads, zero writes
// - idle slave finds start: data falls, clock high
// - eight address bits arrive msb first
// - match acks on ninth pulse; mismatch goes idle
// - read: write pointer, repeated start, then read
// - transfer runs until stop: data rises, clock high
// - start or stop anywhere restarts or idles
// - four pins change role with the mode
// - pointer steps after every data byte
// - master acks each byte read back but the last
// - select transfers ignored; SPI is permanent
package ctrl_port_pkg;
    localparam int         NUM_REGS      = 27;
    localparam logic [7:0] REG_LAST      = 8'h1a;
    localparam logic [7:0] REG_RESET     = 8'h00;
    localparam logic [4:0] DEV_ADDR_LOW5 = 5'h11;
    localparam logic [1:0] SEL_ENTER     = 2'h2;
    localparam int         CLK_HZ        = 10_000_000;
    localparam int         I2C_RATE_HZ   = 100_000;
    localparam int         QTR_CYC       = CLK_HZ / (4 * I2C_RATE_HZ);
    localparam int         SEL_LOW_NS    = 1000;
    localparam int         SEL_LOW_CYC   = (SEL_LOW_NS * (CLK_HZ / 1_000_000)
                                            + 999) / 1000;
endpackage : ctrl_port_pkg

/* File: common/ctrl_port_if.sv */
// shared control pins; the data line is resolved here from both ends
interface ctrl_port_if;
    logic scl;          // serial clock, also spi_serial_clock
    logic latch_pin;    // addr_select_low, also spi_select_n
    logic cin_pin;      // addr_select_high, also spi_serial_in
    logic host_sda_out;
    logic host_sda_oe;
    logic dev_sda_out;  // also spi_serial_out
    logic dev_sda_oe;
    logic sda_line;

    // pull-up: the line is low only while an enabled driver shows zero
    assign sda_line = ~((host_sda_oe & ~host_sda_out)
                        | (dev_sda_oe & ~dev_sda_out));

    modport device (input scl, latch_pin, cin_pin, sda_line,
                    output dev_sda_out, dev_sda_oe);
    modport host (output scl, latch_pin, cin_pin, host_sda_out, host_sda_oe,
                  input sda_line);
endinterface : ctrl_port_if

/* File: rtl/control_port_host.sv */
module control_port_host #(
    parameter int QTR = ctrl_port_pkg::QTR_CYC
) (
    input  wire logic       core_clk_i,
    input  wire logic       rstn_i,
    ctrl_port_if.host       port,
    input  wire logic [1:0] addr_sel_i,
    input  wire logic       cmd_valid_i,
    input  wire logic       cmd_read_i,
    input  wire logic       cmd_select_i,
    input  wire logic [7:0] cmd_reg_i,
    input  wire logic [7:0] cmd_data_i,
    output logic            busy_o,
    output logic            done_o,
    output logic            nack_o,
    output logic [7:0]      rd_data_o
);
    typedef enum logic [1:0] {SY_START, SY_BYTE, SY_STOP} sym_t;

    logic        busy_reg, busy_next, done_reg, done_next;
    logic        nack_reg, nack_next, rd_reg, rd_next;
    logic        sel_reg, sel_next;
    logic [2:0]  step_reg, step_next;
    logic [3:0]  bit_reg, bit_next;
    logic [1:0]  ph_reg, ph_next;
    logic [15:0] tmr_reg, tmr_next;
    logic [7:0]  rx_reg, rx_next, regad_reg, regad_next, wd_reg, wd_next;
    logic [1:0]  as_reg, as_next;
    logic        scl_reg, scl_next, sda_reg, sda_next, lat_reg, lat_next;
    sym_t        sym;
    logic [7:0]  tx_byte;
    logic        tx_bit, last_step;

    // transfer as a list of symbols: write S,A,R,D,P; read S,A,R,S,A,D,P
    always_comb begin
        sym     = SY_BYTE;
        tx_byte = {as_reg, ctrl_port_pkg::DEV_ADDR_LOW5, 1'b0};
        if (step_reg == 3'h0 || (rd_reg && step_reg == 3'h3)) begin
            sym = SY_START;
        end else if (step_reg == (rd_reg ? 3'h6 : 3'h4)) begin
            sym = SY_STOP;
        end
        if (step_reg == 3'h2) begin
            tx_byte = regad_reg;
        end else if (step_reg == 3'h3) begin
            tx_byte = wd_reg;
        end else if (step_reg == 3'h4) begin
            tx_byte = {as_reg, ctrl_port_pkg::DEV_ADDR_LOW5, 1'b1};
        end else if (step_reg == 3'h5) begin
            tx_byte = 8'hff;              // read byte: line left released
        end
        tx_bit    = (bit_reg == 4'h8) ? 1'b1 : tx_byte[3'h7 - bit_reg[2:0]];
        last_step = sym == SY_STOP;
    end

    // one phase every QTR cycles; four phases per start, stop or bit, so 36 per byte
    always_comb begin
        busy_next  = busy_reg;
        done_next  = 1'b0;
        nack_next  = nack_reg;
        rd_next    = rd_reg;
        sel_next   = sel_reg;
        step_next  = step_reg;
        bit_next   = bit_reg;
        ph_next    = ph_reg;
        tmr_next   = tmr_reg;
        rx_next    = rx_reg;
        regad_next = regad_reg;
        wd_next    = wd_reg;
        as_next    = as_reg;
        scl_next   = scl_reg;
        sda_next   = sda_reg;
        lat_next   = busy_reg && sel_reg ? lat_reg : addr_sel_i[0];
        if (!busy_reg) begin
            if (cmd_valid_i) begin
                busy_next  = 1'b1;
                rd_next    = cmd_read_i;
                sel_next   = cmd_select_i;
                regad_next = cmd_reg_i;
                wd_next    = cmd_data_i;
                as_next    = addr_sel_i;
                nack_next  = 1'b0;
                step_next  = 3'h0;
                bit_next   = 4'h0;
                ph_next    = 2'h0;
                tmr_next   = 16'h0000;
            end
        end else if (sel_reg) begin
            // low pulses on the select pin until it has risen three times: three if it starts high, which switch the slave to spi
            tmr_next = tmr_reg + 16'h0001;
            if (tmr_reg == 16'(ctrl_port_pkg::SEL_LOW_CYC - 1)) begin
                tmr_next = 16'h0000;
                lat_next = ~lat_reg;
                if (!lat_reg) begin
                    step_next = step_reg + 3'h1;
                    if (step_reg == 3'h2) begin
                        busy_next = 1'b0;
                        done_next = 1'b1;
                    end
                end
            end
        end else begin
            tmr_next = tmr_reg + 16'h0001;
            if (tmr_reg == 16'(QTR - 1)) begin
                tmr_next = 16'h0000;
                ph_next  = ph_reg + 2'h1;
                case (sym)
                    SY_START: begin
                        scl_next = ph_reg != 2'h3;
                        sda_next = ph_reg < 2'h2;
                    end
                    SY_STOP: begin
                        scl_next = ph_reg != 2'h0;
                        sda_next = ph_reg >= 2'h2;
                    end
                    default: begin
                        scl_next = ph_reg == 2'h1 || ph_reg == 2'h2;
                        sda_next = (step_reg == 3'h5 && bit_reg == 4'h8)
                                   ? 1'b1 : tx_bit;   // nack ends a read
                        if (ph_reg == 2'h2) begin
                            if (bit_reg < 4'h8) begin
                                rx_next = {rx_reg[6:0], port.sda_line};
                            end else if (port.sda_line && step_reg != 3'h5) begin
                                nack_next = 1'b1;
                            end
                        end
                    end
                endcase
                if (ph_reg == 2'h3) begin
                    if (sym == SY_BYTE && bit_reg != 4'h8) begin
                        bit_next = bit_reg + 4'h1;
                    end else begin
                        bit_next  = 4'h0;
                        step_next = (nack_reg && !last_step)
                                    ? (rd_reg ? 3'h6 : 3'h4)
                                    : step_reg + 3'h1;
                        if (last_step) begin
                            busy_next = 1'b0;
                            done_next = 1'b1;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
            nack_reg  <= 1'b0;
            rd_reg    <= 1'b0;
            sel_reg   <= 1'b0;
            step_reg  <= 3'h0;
            bit_reg   <= 4'h0;
            ph_reg    <= 2'h0;
            tmr_reg   <= 16'h0000;
            rx_reg    <= 8'h00;
            regad_reg <= 8'h00;
            wd_reg    <= 8'h00;
            as_reg    <= 2'h0;
            scl_reg   <= 1'b1;
            sda_reg   <= 1'b1;
            lat_reg   <= 1'b0;   // high here would fake a select fall
        end else begin
            busy_reg  <= busy_next;
            done_reg  <= done_next;
            nack_reg  <= nack_next;
            rd_reg    <= rd_next;
            sel_reg   <= sel_next;
            step_reg  <= step_next;
            bit_reg   <= bit_next;
            ph_reg    <= ph_next;
            tmr_reg   <= tmr_next;
            rx_reg    <= rx_next;
            regad_reg <= regad_next;
            wd_reg    <= wd_next;
            as_reg    <= as_next;
            scl_reg   <= scl_next;
            sda_reg   <= sda_next;
            lat_reg   <= lat_next;
        end
    end

    assign port.scl          = scl_reg;
    assign port.latch_pin    = lat_reg;
    assign port.cin_pin      = as_reg[1];
    assign port.host_sda_out = 1'b0;
    assign port.host_sda_oe  = ~sda_reg;   // open drain: enable pulls low
    assign busy_o            = busy_reg;
    assign done_o            = done_reg;
    assign nack_o            = nack_reg;
    assign rd_data_o         = rx_reg;
endmodule : control_port_host

/* File: dv/control_port_properties.sv */
module control_port_properties (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic scl,
    input wire logic latch_pin,
    input wire logic sda_line,
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe,
    input wire logic spi_mode_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // i2c side: the slave only pulls low, and changes the line only while scl is low
    a_reset_quiet: assert property ($rose(rstn_i) |-> !dev_sda_oe
        && !spi_mode_o) else $error("drive after reset");
    a_open_drain: assert property (dev_sda_oe && !spi_mode_o
        |-> !dev_sda_out) else $error("data driven high");
    a_steady_high: assert property (scl && $past(scl) && !spi_mode_o
        |-> $stable(dev_sda_oe)) else $error("data moved in high");
    a_ack_in_low: assert property ($rose(dev_sda_oe) && !spi_mode_o
        |-> !scl) else $error("ack started in high");
    a_bit_holds: assert property ($rose(dev_sda_oe) && !spi_mode_o
        |=> dev_sda_oe [*4]) else $error("ack dropped early");
    a_release_low: assert property ($fell(dev_sda_oe) && !spi_mode_o
        |-> !scl) else $error("release in high");
    // a stop leaves the slave idle, so it must stay off the line
    a_stop_idle: assert property (scl && $past(scl) && $rose(sda_line)
        |=> !dev_sda_oe [*3]) else $error("drive after stop");
    // the switch waits for the third select to end, so its clocks are lost
    a_spi_enter: assert property ($rose(spi_mode_o) |-> latch_pin)
        else $error("mode change inside a select");
    a_spi_sticky: assert property (spi_mode_o |=> spi_mode_o)
        else $error("mode left");
endmodule : control_port_properties

/* File: dv/control_port_i2c_slave_tb.sv */
module control_port_i2c_slave_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       core_clk_i, rstn_i, valid, rd, sel, done, nack, busy;
    logic       strobe, spi_mode, sda_q;
    logic [1:0] addr_sel;
    logic [7:0] creg, cdat, rdat, waddr, wdat, last_a, last_d;
    int         bad_count = 0, total_checks = 0, starts = 0, strobes = 0;
    int         s0, w0;
    ctrl_port_if port ();
    control_port_host #(.QTR(4)) control_port_host_i (.core_clk_i,
        .rstn_i, .port(port.host), .addr_sel_i(addr_sel), .cmd_valid_i(valid),
        .cmd_read_i(rd), .cmd_select_i(sel), .cmd_reg_i(creg),
        .cmd_data_i(cdat), .busy_o(busy), .done_o(done), .nack_o(nack),
        .rd_data_o(rdat));
    control_port_dev control_port_dev_i (.core_clk_i, .rstn_i,
        .port(port.device), .wr_strobe_o(strobe), .wr_addr_o(waddr),
        .wr_data_o(wdat), .spi_mode_o(spi_mode));
    control_port_properties control_port_properties_i (.core_clk_i, .rstn_i,
        .scl(port.scl), .latch_pin(port.latch_pin), .sda_line(port.sda_line),
        .dev_sda_out(port.dev_sda_out), .dev_sda_oe(port.dev_sda_oe),
        .spi_mode_o(spi_mode));
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    // wire watch: starts seen on the line and register writes made
    always @(posedge core_clk_i) begin
        if (port.scl && sda_q && !port.sda_line) starts++;
        if (strobe === 1'b1) begin
            strobes++;
            last_a = waddr;
            last_d = wdat;
        end
        sda_q = port.sda_line;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one command, waited out under a bounded count
    task automatic run(input logic r, input logic s, input logic [7:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        {rd, sel, creg, cdat, valid} = {r, s, a, d, 1'b1};
        s0 = starts;
        w0 = strobes;
        @(posedge core_clk_i);
        #5 valid = 1'b0;
        do begin
            @(posedge core_clk_i);
            #5 n++;
        end while (done !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            bad_count++;
            results();
        end
    endtask : run
    initial begin
        {rstn_i, valid, rd, sel, creg, cdat, addr_sel} = '0;
        repeat (16) @(posedge core_clk_i);
        #5 rstn_i = 1'b1;
        run(1'b1, 1'b0, 8'h05, 8'h00);
        check(rdat, 8'h00);
        check(8'(starts - s0), 8'h02);
        check({7'h00, nack}, 8'h00);
        check({7'h00, busy}, 8'h00);
        $display("test reset read done");
        // every strap setting, writes then reads near the map's top; the
        // select pin only ever steps up here, as a fall would count
        // towards the spi entry
        for (int i = 0; i < 4; i++) begin
            addr_sel = {i[0], i[1]};
            run(1'b0, 1'b0, 8'h17 + 8'(i), 8'ha5 ^ 8'(i));
            check({7'h00, nack}, 8'h00);
            check(8'(strobes - w0), 8'h01);
            check(last_a, 8'h17 + 8'(i));
            check(last_d, 8'ha5 ^ 8'(i));
            check(8'(starts - s0), 8'h01);
            run(1'b1, 1'b0, 8'h17 + 8'(i), 8'h00);
            check(rdat, 8'ha5 ^ 8'(i));
        end
        check({7'h00, spi_mode}, 8'h00);
        $display("test straps done");
        run(1'b0, 1'b0, 8'h1b, 8'h3c);
        check(8'(strobes - w0), 8'h00);
        run(1'b1, 1'b0, 8'h1b, 8'h00);
        check(rdat, 8'h00);
        $display("test outside map done");
        // three selects switch modes once the last one has ended; an i2c
        // read is then ignored
        run(1'b0, 1'b1, 8'h00, 8'h00);
        check(8'(strobes - w0), 8'h00);
        @(posedge core_clk_i);
        #5 check({7'h00, spi_mode}, 8'h01);
        run(1'b1, 1'b0, 8'h00, 8'h00);
        check({7'h00, nack}, 8'h01);
        $display("test mode switch done");
        // a second reset between commands brings back i2c and clears the registers
        rstn_i = 1'b0;
        repeat (2) @(posedge core_clk_i);
        #5 rstn_i = 1'b1;
        check({7'h00, spi_mode}, 8'h00);
        run(1'b1, 1'b0, 8'h1a, 8'h00);
        check({7'h00, nack}, 8'h00);
        check(rdat, 8'h00);
        $display("test second reset done");
        results();
    end
endmodule : control_port_i2c_slave_tb
